// file: core/pqu_cfg.sv
module pqu_cfg
    import pqu_pkg::*;
(
    input wire logic mclk, // Core clock.
    input wire logic rst, // Synchronous reset, active high.
    input wire logic ce, // Clock enable, freezes all state when low except while rst is high.
    input wire logic [11:0] s_axi_awaddr, // Write address.
    input wire logic s_axi_awvalid, // Write address valid.
    output logic s_axi_awready, // Write address ready.
    input wire logic [31:0] s_axi_wdata, // Write data.
    input wire logic [3:0] s_axi_wstrb, // Write byte enables.
    input wire logic s_axi_wvalid, // Write data valid.
    output logic s_axi_wready, // Write data ready.
    output logic [1:0] s_axi_bresp, // Write response.
    output logic s_axi_bvalid, // Write response valid.
    input wire logic s_axi_bready, // Write response ready.
    input wire logic [11:0] s_axi_araddr, // Read address.
    input wire logic s_axi_arvalid, // Read address valid.
    output logic s_axi_arready, // Read address ready.
    output logic [31:0] s_axi_rdata, // Read data.
    output logic [1:0] s_axi_rresp, // Read response.
    output logic s_axi_rvalid, // Read data valid.
    input wire logic s_axi_rready, // Read data ready.
    input wire logic cls_valid, // Frame descriptor valid.
    input wire logic cls_tagged, // Frame carries an 802.1p tag.
    input wire logic [2:0] cls_pcp, // Tag priority code.
    input wire logic [1:0] cls_prio_in, // Priority from the other mapping paths.
    input wire logic cls_two_queue, // Two-queue operation selected.
    input wire logic cls_lookup_miss, // Destination missed the address table.
    input wire logic cls_unicast, // Destination is unicast.
    input wire logic cls_ip_mcast, // Destination is IP multicast.
    output logic res_valid, // Result valid.
    output logic [1:0] res_prio, // Internal priority.
    output logic res_queue_high, // High queue in two-queue operation.
    output logic res_fwd, // Unknown-forward override applies.
    output logic [4:0] res_port_map // Override destination ports.
);

    // ****************************************************************
    // Configuration storage.
    // ****************************************************************
    logic [1:0] tag4_map, next_tag4_map;
    logic [1:0] two_queue_split_field, next_two_queue_split_field;
    logic uc_en, next_uc_en;
    logic [4:0] uc_map, next_uc_map;
    logic mc_en, next_mc_en;
    logic [4:0] mc_map, next_mc_map;

    // ****************************************************************
    // Bus slave state.
    // ****************************************************************
    logic aw_held, next_aw_held;
    logic [11:0] aw_addr, next_aw_addr;
    logic w_held, next_w_held;
    logic [7:0] w_byte, next_w_byte;
    logic w_lane, next_w_lane;
    logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
    logic [1:0] next_bresp, next_rresp;
    logic [31:0] next_rdata;
    logic wr_fire;
    logic [7:0] wr_idx, rd_idx;
    logic wr_hit, rd_hit;

    // Decode a byte address into a register index; only aligned words hit.
    function automatic logic decode(input logic [11:0] addr, output logic [7:0] idx);
        idx = addr[9:2];
        decode = (addr[1:0] == 2'h0) && (addr[11:10] == 2'h0) &&
                 (idx >= PQU_IDX_TAG4_MAP) && (idx <= PQU_IDX_MC_FWD);
    endfunction

    // Write channel: address and data are taken in either order, the answer follows both.
    // A new request is held off until the answer has been taken so one write is in flight.
    always_comb begin
        next_aw_held = aw_held;
        next_aw_addr = aw_addr;
        next_w_held = w_held;
        next_w_byte = w_byte;
        next_w_lane = w_lane;
        next_bvalid = s_axi_bvalid;
        next_bresp = s_axi_bresp;
        wr_fire = 1'b0;
        wr_hit = decode(aw_addr, wr_idx);
        if (s_axi_awvalid && s_axi_awready) begin
            next_aw_held = 1'b1;
            next_aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_w_held = 1'b1;
            next_w_byte = s_axi_wdata[7:0];
            next_w_lane = s_axi_wstrb[0];
        end
        if (s_axi_bvalid && s_axi_bready) begin
            next_bvalid = 1'b0;
        end
        if (aw_held && w_held && !s_axi_bvalid) begin
            wr_fire = 1'b1;
            next_aw_held = 1'b0;
            next_w_held = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = wr_hit ? PQU_RESP_OKAY : PQU_RESP_SLVERR;
        end
        next_awready = !next_aw_held && !next_bvalid;
        next_wready = !next_w_held && !next_bvalid;
    end

    // Register writes; only byte lane 0 carries data, the upper lanes are ignored.
    always_comb begin
        next_tag4_map = tag4_map;
        next_two_queue_split_field = two_queue_split_field;
        next_uc_en = uc_en;
        next_uc_map = uc_map;
        next_mc_en = mc_en;
        next_mc_map = mc_map;
        if (wr_fire && wr_hit && w_lane) begin
            unique case (wr_idx)
                PQU_IDX_TAG4_MAP: next_tag4_map = w_byte[PQU_TAG4_LSB +: 2];
                PQU_IDX_SPLIT: next_two_queue_split_field = w_byte[PQU_SPLIT_LSB +: 2];
                PQU_IDX_UC_FWD: begin
                    next_uc_en = w_byte[PQU_FWD_EN_BIT];
                    next_uc_map = w_byte[PQU_MAP_LSB +: PQU_MAP_W] & PQU_MAP_WMASK;
                end
                PQU_IDX_MC_FWD: begin
                    next_mc_en = w_byte[PQU_FWD_EN_BIT];
                    next_mc_map = w_byte[PQU_MAP_LSB +: PQU_MAP_W] & PQU_MAP_WMASK;
                end
                default: ;
            endcase
        end
    end

    // Read channel: one read at a time, answered the cycle after the address is taken.
    always_comb begin
        next_arready = s_axi_arready;
        next_rvalid = s_axi_rvalid;
        next_rdata = s_axi_rdata;
        next_rresp = s_axi_rresp;
        rd_hit = decode(s_axi_araddr, rd_idx);
        if (s_axi_rvalid && s_axi_rready) begin
            next_rvalid = 1'b0;
            next_arready = 1'b1;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            next_arready = 1'b0;
            next_rvalid = 1'b1;
            next_rresp = rd_hit ? PQU_RESP_OKAY : PQU_RESP_SLVERR;
            next_rdata = 32'h0000_0000;
            if (rd_hit) begin
                unique case (rd_idx)
                    PQU_IDX_TAG4_MAP: next_rdata[7:0] = {6'h00, tag4_map};
                    PQU_IDX_SPLIT: next_rdata[7:0] = {two_queue_split_field, PQU_SPLIT_RSVD};
                    PQU_IDX_UC_FWD: next_rdata[7:0] = {PQU_UC_RSVD, uc_en, uc_map};
                    PQU_IDX_MC_FWD: next_rdata[7:0] = {PQU_MC_RSVD, mc_en, mc_map};
                    default: ;
                endcase
            end
        end
    end

    // Bus and configuration registers.
    always_ff @(posedge mclk) begin
        if (rst) begin
            aw_held <= 1'b0;
            aw_addr <= 12'h000;
            w_held <= 1'b0;
            w_byte <= 8'h00;
            w_lane <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= PQU_RESP_OKAY;
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= PQU_RESP_OKAY;
            tag4_map <= PQU_TAG4_RST;
            two_queue_split_field <= PQU_SPLIT_RST;
            uc_en <= PQU_FWD_EN_RST;
            uc_map <= PQU_MAP_RST;
            mc_en <= PQU_FWD_EN_RST;
            mc_map <= PQU_MAP_RST;
        end else if (ce) begin
            aw_held <= next_aw_held;
            aw_addr <= next_aw_addr;
            w_held <= next_w_held;
            w_byte <= next_w_byte;
            w_lane <= next_w_lane;
            s_axi_awready <= next_awready;
            s_axi_wready <= next_wready;
            s_axi_bvalid <= next_bvalid;
            s_axi_bresp <= next_bresp;
            s_axi_arready <= next_arready;
            s_axi_rvalid <= next_rvalid;
            s_axi_rdata <= next_rdata;
            s_axi_rresp <= next_rresp;
            tag4_map <= next_tag4_map;
            two_queue_split_field <= next_two_queue_split_field;
            uc_en <= next_uc_en;
            uc_map <= next_uc_map;
            mc_en <= next_mc_en;
            mc_map <= next_mc_map;
        end
    end

    // ****************************************************************
    // Frame classification.
    // ****************************************************************
    pqu_fwd_if uc_if ();
    pqu_fwd_if mc_if ();
    logic [1:0] cls_prio;
    logic fold_high;
    logic next_res_valid, next_res_queue_high, next_res_fwd;
    logic [1:0] next_res_prio;
    logic [4:0] next_res_port_map;

    // tag four mapping
    // A tagged frame with code four takes the programmed value; others keep their result.
    always_comb begin
        cls_prio = (cls_tagged && cls_pcp == PQU_PCP_MAPPED) ? tag4_map : cls_prio_in;
    end

    pqu_fold u_fold (
        .prio(cls_prio),
        .split(two_queue_split_field),
        .high(fold_high)
    );

    always_comb begin
        uc_if.hit = cls_lookup_miss && cls_unicast;
        uc_if.en = uc_en;
        uc_if.map = uc_map;
        mc_if.hit = cls_lookup_miss && !cls_unicast && !cls_ip_mcast;
        mc_if.en = mc_en;
        mc_if.map = mc_map;
    end

    pqu_fwd_sel u_uc_sel (
        .fwd(uc_if)
    );

    pqu_fwd_sel u_mc_sel (
        .fwd(mc_if)
    );

    // Result registers; a frame the override does not cover reports no ports at all.
    always_comb begin
        next_res_valid = cls_valid;
        next_res_prio = cls_prio;
        next_res_queue_high = cls_two_queue && fold_high;
        next_res_fwd = uc_if.take || mc_if.take;
        next_res_port_map = uc_if.ports | mc_if.ports;
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            res_valid <= 1'b0;
            res_prio <= 2'h0;
            res_queue_high <= 1'b0;
            res_fwd <= 1'b0;
            res_port_map <= 5'h00;
        end else if (ce) begin
            res_valid <= next_res_valid;
            res_prio <= next_res_prio;
            res_queue_high <= next_res_queue_high;
            res_fwd <= next_res_fwd;
            res_port_map <= next_res_port_map;
        end
    end

    // ****************************************************************
    // Checks.
    // ****************************************************************
    sequence cls_tag4_s;
        ce && cls_valid && cls_tagged && cls_pcp == PQU_PCP_MAPPED;
    endsequence

    sequence cls_uc_miss_s;
        ce && cls_valid && cls_lookup_miss && cls_unicast;
    endsequence

    tag4_prio_a: assert property (@(posedge mclk) disable iff (rst)
        cls_tag4_s |=> res_valid && res_prio == $past(tag4_map))
        else $error("Tag four frame did not take the mapped priority.");

    split_fold_a: assert property (@(posedge mclk) disable iff (rst)
        (ce && cls_two_queue && cls_prio == 2'h2) |=> res_queue_high == $past(two_queue_split_field[1]))
        else $error("Priority two folded against the split setting.");

    fold_ends_a: assert property (@(posedge mclk) disable iff (rst)
        (ce && cls_two_queue && cls_prio[0] == cls_prio[1]) |=> res_queue_high == $past(cls_prio[1]))
        else $error("Priority zero or three folded into the wrong queue.");

    uc_enable_a: assert property (@(posedge mclk) disable iff (rst)
        cls_uc_miss_s |=> res_fwd == $past(uc_en))
        else $error("Unknown unicast override ignored its enable.");

    uc_map_a: assert property (@(posedge mclk) disable iff (rst)
        (cls_uc_miss_s ##0 uc_en) |=> res_port_map == ($past(uc_map) & PQU_MAP_WMASK) && !res_port_map[PQU_MAP_RSVD_BIT])
        else $error("Unknown unicast ports differ from the bitmap.");

    ip_mcast_excl_a: assert property (@(posedge mclk) disable iff (rst)
        (ce && cls_lookup_miss && !cls_unicast && cls_ip_mcast) |=> !res_fwd && res_port_map == 5'h00)
        else $error("IP multicast took the unknown multicast override.");

    mc_map_a: assert property (@(posedge mclk) disable iff (rst)
        (ce && cls_lookup_miss && !cls_unicast && !cls_ip_mcast && mc_en) |=>
        res_fwd && res_port_map == ($past(mc_map) & PQU_MAP_WMASK))
        else $error("Unknown multicast ports differ from the bitmap.");

    known_dst_a: assert property (@(posedge mclk) disable iff (rst)
        (ce && !cls_lookup_miss) |=> !res_fwd && res_port_map == 5'h00)
        else $error("Known destination took the unknown override.");

endmodule // pqu_cfg

// file: core/pqu_pkg.sv
package pqu_pkg;

    // ****************************************************************
    // Register indices. The byte address is four times the index.
    // ****************************************************************
    localparam logic [7:0] PQU_IDX_TAG4_MAP = 8'h81;
    localparam logic [7:0] PQU_IDX_SPLIT = 8'h82;
    localparam logic [7:0] PQU_IDX_UC_FWD = 8'h83;
    localparam logic [7:0] PQU_IDX_MC_FWD = 8'h84;

    // ****************************************************************
    // Field positions and widths.
    // ****************************************************************
    localparam int PQU_TAG4_LSB = 0;
    localparam int PQU_SPLIT_LSB = 6;
    localparam int PQU_FWD_EN_BIT = 5;
    localparam int PQU_MAP_LSB = 0;
    localparam int PQU_MAP_W = 5;
    localparam int PQU_MAP_RSVD_BIT = 3;

    // ****************************************************************
    // Reset values, fixed read-back of reserved bits and the port bitmap write mask.
    // ****************************************************************
    localparam logic [1:0] PQU_TAG4_RST = 2'h2;
    localparam logic [1:0] PQU_SPLIT_RST = 2'h2;
    localparam logic PQU_FWD_EN_RST = 1'h0;
    localparam logic [4:0] PQU_MAP_RST = 5'h00;
    localparam logic [5:0] PQU_SPLIT_RSVD = 6'h08;
    localparam logic [1:0] PQU_UC_RSVD = 2'h2;
    localparam logic [1:0] PQU_MC_RSVD = 2'h1;
    localparam logic [4:0] PQU_MAP_WMASK = 5'h17;

    // ****************************************************************
    // Frame classification constants, bus answers and the bus address width.
    // ****************************************************************
    localparam logic [2:0] PQU_PCP_MAPPED = 3'h4;
    localparam logic [1:0] PQU_RESP_OKAY = 2'h0;
    localparam logic [1:0] PQU_RESP_SLVERR = 2'h2;
    localparam int PQU_ADDR_W = 12;

endpackage : pqu_pkg

// file: core/pqu_fwd_if.sv
// Carries one unknown-destination forwarding decision between the core and a selector.
interface pqu_fwd_if;
    logic hit;
    logic en;
    logic [4:0] map;
    logic take;
    logic [4:0] ports;
    modport unit (input hit, input en, input map, output take, output ports);
    modport core (output hit, output en, output map, input take, input ports);
endinterface : pqu_fwd_if

// file: core/pqu_fwd_sel.sv
// ****************************************************************
// Unknown-destination forwarding selector.
// ****************************************************************
module pqu_fwd_sel
    import pqu_pkg::*;
(
    pqu_fwd_if.unit fwd // Decision request and answer.
);

    // The override applies only to a frame of this class that missed the table;
    // the reserved port bit never forwards, whatever was written.
    always_comb begin
        fwd.take = fwd.hit & fwd.en;
        fwd.ports = fwd.take ? (fwd.map & PQU_MAP_WMASK) : 5'h00;
    end

endmodule // pqu_fwd_sel

// file: core/pqu_fold.sv
// ****************************************************************
// Two-queue fold of a 2-bit priority result.
// ****************************************************************
module pqu_fold (
    input wire logic [1:0] prio, // Four-level priority result.
    input wire logic [1:0] split, // Split setting.
    output logic high // High queue selected.
);

    // fixed end results
    // Result 0 is always low and 3 always high; 1 and 2 follow one split bit each.
    // The unsupported split code simply falls out of the same equation.
    always_comb begin
        unique case (prio)
            2'h0: high = 1'b0;
            2'h1: high = split[0];
            2'h2: high = split[1];
            2'h3: high = 1'b1;
        endcase
    end

endmodule // pqu_fold

// file: tb/pqu_cfg_tb.sv
module tb
    import pqu_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    logic [11:0] awaddr = 12'h000;
    logic awvalid = 1'b0;
    logic awready;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'hf;
    logic wvalid = 1'b0;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    logic bready = 1'b0;
    logic [11:0] araddr = 12'h000;
    logic arvalid = 1'b0;
    logic arready;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
    logic rready = 1'b0;
    logic c_valid = 1'b0;
    logic c_tagged = 1'b0;
    logic [2:0] c_pcp = 3'h0;
    logic [1:0] c_pin = 2'h0;
    logic c_tq = 1'b0;
    logic c_miss = 1'b0;
    logic c_uc = 1'b0;
    logic c_ip = 1'b0;
    logic r_valid;
    logic [1:0] r_prio;
    logic r_high;
    logic r_fwd;
    logic [4:0] r_map;
    int bad_count = 0;
    int n_checks = 0;

    // Free-running core clock at 100 MHz.
    always #5 mclk = ~mclk;

    pqu_cfg pqu_cfg_inst (
        .mclk(mclk), .rst(rst), .ce(ce),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .cls_valid(c_valid), .cls_tagged(c_tagged), .cls_pcp(c_pcp), .cls_prio_in(c_pin),
        .cls_two_queue(c_tq), .cls_lookup_miss(c_miss), .cls_unicast(c_uc), .cls_ip_mcast(c_ip),
        .res_valid(r_valid), .res_prio(r_prio), .res_queue_high(r_high), .res_fwd(r_fwd),
        .res_port_map(r_map)
    );

    // ****************************************************************
    // Checking and closing.
    // ****************************************************************
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    task automatic print_verdict();
        $display("Checks made: %0d, mismatches: %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // A wait that runs out counts as a mismatch and ends the run.
    task automatic give_up();
        bad_count++;
        $display("BAD at %0t: bus answer never came", $time);
        print_verdict();
    endtask

    // ****************************************************************
    // Register bus master tasks.
    // ****************************************************************
    // Address and data are offered together; each is released on its own handshake edge.
    task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] e_resp);
        bit aw_done;
        bit w_done;
        aw_done = 0;
        w_done = 0;
        @(posedge mclk);
        awaddr <= {2'b00, idx, 2'b00};
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (int i = 0; i < 50; i++) begin
            @(posedge mclk);
            if (bvalid === 1'b1) begin
                bready <= 1'b0;
                chk(32'(bresp), 32'(e_resp));
                return;
            end
            if (!aw_done && awready === 1'b1) begin
                aw_done = 1;
                awvalid <= 1'b0;
            end
            if (!w_done && wready === 1'b1) begin
                w_done = 1;
                wvalid <= 1'b0;
            end
        end
        give_up();
    endtask

    task automatic rd(input logic [7:0] idx, input logic [7:0] e_data, input logic [1:0] e_resp);
        bit a_done;
        a_done = 0;
        @(posedge mclk);
        araddr <= {2'b00, idx, 2'b00};
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (int i = 0; i < 50; i++) begin
            @(posedge mclk);
            if (rvalid === 1'b1) begin
                rready <= 1'b0;
                chk(rdata, {24'h0, e_data});
                chk(32'(rresp), 32'(e_resp));
                return;
            end
            if (!a_done && arready === 1'b1) begin
                a_done = 1;
                arvalid <= 1'b0;
            end
        end
        give_up();
    endtask

    // One frame descriptor; the result is compared one cycle later.
    task automatic frame(input logic tg, input logic [2:0] pcp, input logic [1:0] pin, input logic tq,
                         input logic miss, input logic uc, input logic ip, input logic [1:0] e_prio,
                         input logic e_high, input logic e_fwd, input logic [4:0] e_map);
        @(posedge mclk);
        c_valid <= 1'b1;
        c_tagged <= tg;
        c_pcp <= pcp;
        c_pin <= pin;
        c_tq <= tq;
        c_miss <= miss;
        c_uc <= uc;
        c_ip <= ip;
        @(posedge mclk);
        #1;
        chk(32'(r_valid), 32'h1);
        chk(32'(r_prio), 32'(e_prio));
        chk(32'(r_high), 32'(e_high));
        chk(32'(r_fwd), 32'(e_fwd));
        chk(32'(r_map), 32'(e_map));
    endtask

    // ****************************************************************
    // Test sequence.
    // ****************************************************************
    initial begin
        logic [1:0] sp;
        logic eh;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        rd(PQU_IDX_TAG4_MAP, 8'h02, PQU_RESP_OKAY);
        rd(PQU_IDX_SPLIT, 8'h88, PQU_RESP_OKAY);
        rd(PQU_IDX_UC_FWD, 8'h80, PQU_RESP_OKAY);
        rd(PQU_IDX_MC_FWD, 8'h40, PQU_RESP_OKAY);
        rd(8'h85, 8'h00, PQU_RESP_SLVERR);
        wr(8'h85, 8'hff, PQU_RESP_SLVERR);
        $display("Test reset values done");

        // Tag four takes the mapping field; other tags keep the incoming priority.
        frame(1, 3'h4, 2'h0, 0, 0, 0, 0, 2'h2, 0, 0, 5'h00);
        wr(PQU_IDX_TAG4_MAP, 8'hfd, PQU_RESP_OKAY);
        rd(PQU_IDX_TAG4_MAP, 8'h01, PQU_RESP_OKAY);
        // A write without byte lane 0 is answered but leaves the field alone.
        wstrb <= 4'he;
        wr(PQU_IDX_TAG4_MAP, 8'h03, PQU_RESP_OKAY);
        wstrb <= 4'hf;
        rd(PQU_IDX_TAG4_MAP, 8'h01, PQU_RESP_OKAY);
        frame(1, 3'h4, 2'h3, 0, 0, 0, 0, 2'h1, 0, 0, 5'h00);
        frame(1, 3'h5, 2'h3, 0, 0, 0, 0, 2'h3, 0, 0, 5'h00);
        frame(0, 3'h4, 2'h0, 0, 0, 0, 0, 2'h0, 0, 0, 5'h00);
        $display("Test tag four mapping done");

        // Software only programs the supported split settings 00, 10 and 11.
        // supported settings only
        for (int s = 0; s < 3; s++) begin
            sp = (s == 0) ? 2'h0 : (s == 1) ? 2'h3 : 2'h2;
            wr(PQU_IDX_SPLIT, {sp, 6'h3f}, PQU_RESP_OKAY);
            rd(PQU_IDX_SPLIT, {sp, 6'h08}, PQU_RESP_OKAY);
            for (int p = 0; p < 4; p++) begin
                eh = (sp == 2'h0) ? (p == 3) : (sp == 2'h2) ? (p >= 2) : (p >= 1);
                frame(0, 3'h0, 2'(p), 1, 0, 0, 0, 2'(p), eh, 0, 5'h00);
            end
        end
        frame(0, 3'h0, 2'h3, 0, 0, 0, 0, 2'h3, 0, 0, 5'h00);
        $display("Test two-queue fold done");

        // Unknown unicast: disabled at reset, then flooded with reserved bit 3 held at zero.
        frame(0, 3'h0, 2'h0, 0, 1, 1, 0, 2'h0, 0, 0, 5'h00);
        wr(PQU_IDX_UC_FWD, 8'hff, PQU_RESP_OKAY);
        rd(PQU_IDX_UC_FWD, 8'hb7, PQU_RESP_OKAY);
        frame(0, 3'h0, 2'h0, 0, 1, 1, 0, 2'h0, 0, 1, 5'h17);
        frame(0, 3'h0, 2'h0, 0, 0, 1, 0, 2'h0, 0, 0, 5'h00);
        frame(0, 3'h0, 2'h0, 0, 1, 0, 0, 2'h0, 0, 0, 5'h00);
        wr(PQU_IDX_UC_FWD, 8'h20, PQU_RESP_OKAY);
        frame(0, 3'h0, 2'h0, 0, 1, 1, 0, 2'h0, 0, 1, 5'h00);
        wr(PQU_IDX_UC_FWD, 8'h06, PQU_RESP_OKAY);
        frame(0, 3'h0, 2'h0, 0, 1, 1, 0, 2'h0, 0, 0, 5'h00);
        $display("Test unknown unicast done");

        // Unknown non-IP multicast follows its own enable and bitmap.
        wr(PQU_IDX_MC_FWD, 8'h29, PQU_RESP_OKAY);
        rd(PQU_IDX_MC_FWD, 8'h61, PQU_RESP_OKAY);
        frame(0, 3'h0, 2'h0, 0, 1, 0, 0, 2'h0, 0, 1, 5'h01);
        frame(0, 3'h0, 2'h0, 0, 1, 0, 1, 2'h0, 0, 0, 5'h00);
        frame(0, 3'h0, 2'h0, 0, 0, 0, 0, 2'h0, 0, 0, 5'h00);
        frame(0, 3'h0, 2'h0, 0, 1, 1, 0, 2'h0, 0, 0, 5'h00);
        $display("Test unknown multicast done");

        // With the clock enable low the result registers hold their last frame.
        @(posedge mclk);
        ce <= 1'b0;
        c_pin <= 2'h1;
        repeat (3) @(posedge mclk);
        #1;
        chk(32'(r_prio), 32'h0);
        @(posedge mclk);
        ce <= 1'b1;
        c_valid <= 1'b0;
        // Once enabled again, a cycle with no descriptor reports no result.
        @(posedge mclk);
        #1;
        chk(32'(r_valid), 32'h0);
        $display("Test clock enable hold done");
        print_verdict();
    end

endmodule // tb
